// ===== scr_core_regs.sv
/*
 * scr_core_regs: host register bank of the scsi protocol controller
 * core: byte counter, 16x2-byte data queue, two-deep operation queue,
 * status, ids, event cause and odd-byte handling on data-in.
 * assumes one clock, synchronous inputs, strobes one cycle long and
 * never both at once; bytes from the scsi side arrive on i_scsi_*.
 */
// The address-and-strobe port is this design's own decision.
// How it works
// RL1: by default an odd final data-in byte stays in the queue and the core interrupts while it is held.
// RL2: in that default mode the driver writes one pad byte, reads both bytes back and drops the pad.
// RL3: with config3 bit 7 set the core pads the last byte itself and interrupts once the engine drained all.
// RL4: the pad option bit clears on every reset so the hold-last-byte mode is back after reset.
// RL5: a 16-bit byte counter counts bytes moved by a dma operation or received in target mode.
// RL6: issuing a dma operation loads the counter from the load registers, then each byte decrements it.
// RL7: after an early end, counter plus queue occupancy gives the bytes still to move.
// RL8: the host programs the transfer count before it writes a dma operation.
// RL9: the data queue holds 16 entries of two bytes, filled at the top and drained at the bottom.
// RL10: the operation register is a two-deep queue so a second operation can wait behind the first.
// RL11: each operation code splits into a dma flag, a mode field and an operation field.
// RL12: the read-only phase status reports core state, bus phase and interrupt qualifiers.
// RL13: the event cause register shows the finished operation and clears when read while pending.
// RL14: the write-only id register stores the own bus id and the selection target id.
// RL15: the host loads the time-out register for about 250 ms of selection wait.
// RL16: the sequence step stays latched until the event cause is read while pending, then goes to zero.
// RL17: on shared addresses reads return the read-only register and writes touch only the write-only one.
`timescale 1ns/1ps
module scr_core_regs #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	// register port
	input  wire logic [scr_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [scr_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic      [scr_pkg::DATA_W-1:0] o_rdata,
	// scsi data-in byte stream
	input  wire logic                    i_scsi_valid,
	input  wire logic [7:0]              i_scsi_byte,
	output logic                         o_scsi_ready,
	input  wire logic [2:0]              i_bus_phase,
	// dma channel engine side
	input  wire logic                    i_dma_rd,
	output scr_pkg::scr_dma_word_t       o_dma_word,
	output logic                         o_dma_avail,
	// configuration seen by the bus logic
	output logic      [7:0]              o_bus_id,
	output logic      [7:0]              o_sel_timeout,
	// interrupt
	output logic                         o_irq
);
	import scr_pkg::*;

	localparam int PW = $clog2(DEPTH) + 1;   // byte pointer width
	localparam int OW = PW + 1;              // occupancy width
	localparam logic [OW-1:0] CAP = OW'(2 * DEPTH);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic wr_cnt_lo, wr_cnt_hi, wr_port, wr_op, wr_id, wr_tmo;
	logic wr_cfg, wr_stat, wr_mask;
	logic rd_port, rd_cause;
	assign wr_cnt_lo = i_wr && i_addr == OFS_COUNT_LOW;   // RL17
	assign wr_cnt_hi = i_wr && i_addr == OFS_COUNT_HIGH;  // RL17
	assign wr_port   = i_wr && i_addr == OFS_DATA_PORT;
	assign wr_op     = i_wr && i_addr == OFS_OP_QUEUE;
	assign wr_id     = i_wr && i_addr == OFS_PHASE_ID;    // RL17
	assign wr_tmo    = i_wr && i_addr == OFS_CAUSE_TMO;   // RL17
	assign wr_cfg    = i_wr && i_addr == OFS_CONFIG3;
	assign wr_stat   = i_wr && i_addr == OFS_IRQ_STAT;
	assign wr_mask   = i_wr && i_addr == OFS_IRQ_MASK;
	assign rd_port   = i_rd && i_addr == OFS_DATA_PORT;
	assign rd_cause  = i_rd && i_addr == OFS_CAUSE_TMO;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0]          load_ff;
	logic [15:0]          cnt_ff;
	logic [15:0]          mem_ff [DEPTH];
	logic [PW-1:0]        wp_ff;
	logic [PW-1:0]        rp_ff;
	logic [OW-1:0]        occ_ff;
	scr_cmd_t             opq_ff [2];
	logic [1:0]           opn_ff;
	scr_state_t           st_ff;
	logic [7:0]           cfg3_ff;
	logic [7:0]           cause_ff;
	logic [7:0]           seq_ff;
	logic [IRQ_W-1:0]     ist_ff;
	logic [IRQ_W-1:0]     imask_ff;
	logic                 flush;
	logic                 done_hit;

	// ----------------------------------------------------------------
	// queue push and pop selection
	// ----------------------------------------------------------------
	logic       scsi_take, host_push, push;
	logic [7:0] push_byte;
	logic       word_ok, pad_ok, dma_pop, pad_pop;
	logic [1:0] pop_n;
	logic       refused;
	logic       pad_mode;

	assign pad_mode  = cfg3_ff[CFG3_PAD_BIT];
	// the scsi side only moves bytes while a transfer runs
	assign scsi_take = i_scsi_valid && o_scsi_ready && st_ff == ST_XFER;
	assign host_push = wr_port && !scsi_take && occ_ff < CAP;
	assign push      = scsi_take || host_push;
	assign push_byte = scsi_take ? i_scsi_byte : i_wdata[7:0];
	// a whole word sits at the bottom
	assign word_ok   = occ_ff >= OW'(2) && !rp_ff[0];
	// a lone last byte is handed out padded only in pad mode
	assign pad_ok    = pad_mode && occ_ff == OW'(1) && cnt_ff == 16'h0000
	                   && st_ff == ST_XFER;                        // RL3
	assign dma_pop   = i_dma_rd && !rd_port && (word_ok || pad_ok);
	assign pad_pop   = dma_pop && !word_ok;
	always_comb begin
		pop_n = 2'd0;
		if (rd_port && occ_ff != '0)
			pop_n = 2'd1;
		else if (dma_pop)
			pop_n = pad_pop ? 2'd1 : 2'd2;
	end
	assign refused = (wr_port && !host_push) || (wr_op && opn_ff == 2'd2);

	logic [OW-1:0] nxt_occ;
	always_comb begin
		nxt_occ = occ_ff + OW'(push) - OW'(pop_n);
		if (flush)
			nxt_occ = '0;
	end

	// ----------------------------------------------------------------
	// data queue: 16 entries of two bytes, top in, bottom out
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			occ_ff <= '0;
		end else begin
			occ_ff <= nxt_occ;                                 // RL9
			if (flush) begin
				wp_ff <= '0;
				rp_ff <= '0;
			end else begin
				if (push)
					wp_ff <= wp_ff + PW'(1);                   // RL9
				if (pop_n != 2'd0)
					rp_ff <= rp_ff + PW'(pop_n);               // RL9
			end
		end
	end

	// storage, one generate branch per entry
	for (genvar e = 0; e < DEPTH; e++) begin : g_entry
		always_ff @(posedge i_ref_clk) begin
			if (!i_reset_n)
				mem_ff[e] <= 16'h0000;
			else if (push && wp_ff[PW-1:1] == (PW-1)'(e)) begin
				if (wp_ff[0])
					mem_ff[e][15:8] <= push_byte;
				else
					mem_ff[e][7:0] <= push_byte;
			end
		end
	end

	logic [15:0] bot_word;
	logic [7:0]  bot_byte;
	assign bot_word = mem_ff[rp_ff[PW-1:1]];
	assign bot_byte = rp_ff[0] ? bot_word[15:8] : bot_word[7:0];

	// ready keeps one byte of slack for a host push; a scsi byte in the same cycle wins and the host push is refused
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			o_scsi_ready <= 1'b0;
		else
			o_scsi_ready <= nxt_occ < CAP - OW'(1);
	end

	// dma engine word, with pad byte on a lone last byte
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_dma_word  <= '0;
			o_dma_avail <= 1'b0;
		end else begin
			o_dma_word.valid  <= dma_pop;
			o_dma_word.padded <= pad_pop;
			if (dma_pop)
				o_dma_word.data <= pad_pop ? {PAD_BYTE, bot_byte} : bot_word; // RL3
			o_dma_avail <= nxt_occ >= OW'(2) || (pad_mode && nxt_occ == OW'(1));
		end
	end

	// ----------------------------------------------------------------
	// operation queue, two deep
	// ----------------------------------------------------------------
	scr_cmd_t head;
	logic     op_pop;
	assign head   = opq_ff[0];                                 // RL11
	assign op_pop = st_ff == ST_DONE;
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			opq_ff[0] <= '0;
			opq_ff[1] <= '0;
			opn_ff    <= 2'd0;
		end else begin
			case ({op_pop, wr_op && opn_ff != 2'd2})
				2'b01: begin
					opq_ff[opn_ff[0]] <= scr_cmd_t'(i_wdata[7:0]); // RL10
					opn_ff            <= opn_ff + 2'd1;
				end
				2'b10: begin
					opq_ff[0] <= opq_ff[1];
					opn_ff    <= opn_ff - 2'd1;
				end
				2'b11: begin
					if (opn_ff == 2'd2)
						opq_ff[0] <= opq_ff[1];
					if (opn_ff == 2'd2)
						opq_ff[1] <= scr_cmd_t'(i_wdata[7:0]); // RL10
					else
						opq_ff[0] <= scr_cmd_t'(i_wdata[7:0]);
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// execution sequencer
	// ----------------------------------------------------------------
	logic issue;
	assign issue = st_ff == ST_IDLE && opn_ff != 2'd0;
	assign flush = issue && head.op == OP_FLUSH;
	// default mode ends with at most one lone byte still held
	assign done_hit = st_ff == ST_XFER && cnt_ff == 16'h0000
	                  && (pad_mode ? occ_ff == '0 : occ_ff < OW'(2)); // RL1 RL3

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			st_ff <= ST_IDLE;
		else begin
			case (st_ff)
				ST_IDLE: begin
					if (issue)
						st_ff <= head.op == OP_XFER ? ST_XFER : ST_DONE; // RL11
				end
				ST_XFER: begin
					if (done_hit)
						st_ff <= ST_DONE;
				end
				ST_DONE: st_ff <= ST_IDLE;
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// byte counter: load on a dma issue, one down per byte
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			load_ff <= 16'h0000;
			cnt_ff  <= 16'h0000;
		end else begin
			if (wr_cnt_lo)
				load_ff[7:0] <= i_wdata[7:0];
			if (wr_cnt_hi)
				load_ff[15:8] <= i_wdata[7:0];
			if (issue && head.dma)
				cnt_ff <= load_ff;                             // RL6 RL8
			else if (scsi_take && cnt_ff != 16'h0000)
				cnt_ff <= cnt_ff - 16'h0001;                   // RL5 RL6 RL7
		end
	end

	// ----------------------------------------------------------------
	// event cause and sequence step
	// ----------------------------------------------------------------
	logic pending;
	assign pending = cause_ff != 8'h00;
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			cause_ff <= 8'h00;
			seq_ff   <= 8'h00;
		end else if (op_pop) begin
			cause_ff <= 8'h01 << CAUSE_DONE_BIT;               // RL13
			seq_ff   <= SEQ_DONE;
		end else if (rd_cause && pending) begin
			cause_ff <= 8'h00;                                 // RL13
			seq_ff   <= 8'h00;                                 // RL16
		end
	end

	// ----------------------------------------------------------------
	// setup registers: write-only id and time-out, read/write config3
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_bus_id      <= 8'h00;
			o_sel_timeout <= 8'h00;
			cfg3_ff       <= CFG3_RESET;                       // RL4
		end else begin
			if (wr_id)
				o_bus_id <= i_wdata[7:0];                      // RL14
			if (wr_tmo)
				o_sel_timeout <= i_wdata[7:0];                 // RL15
			if (wr_cfg)
				cfg3_ff <= i_wdata[7:0];                       // RL3
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, mask and output
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] nxt_ist;
	always_comb begin
		ev               = '0;
		ev[IRQ_DONE]     = op_pop;
		ev[IRQ_ODD_HELD] = done_hit && !pad_mode && occ_ff == OW'(1); // RL1
		ev[IRQ_REFUSED]  = refused;
		nxt_ist          = ist_ff;
		if (wr_stat)
			nxt_ist = nxt_ist & ~i_wdata[IRQ_W-1:0];
		nxt_ist = nxt_ist | ev;                                // set wins
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			ist_ff   <= '0;
			imask_ff <= '0;
			o_irq    <= 1'b0;
		end else begin
			ist_ff <= nxt_ist;
			if (wr_mask)
				imask_ff <= i_wdata[IRQ_W-1:0];
			o_irq <= |(nxt_ist & (wr_mask ? i_wdata[IRQ_W-1:0] : imask_ff));
		end
	end

	// ----------------------------------------------------------------
	// read mux, data one cycle after the strobe
	// ----------------------------------------------------------------
	logic [7:0] phase_st;
	always_comb begin
		phase_st      = 8'h00;
		phase_st[7]   = pending;                               // RL12
		phase_st[6]   = opn_ff == 2'd2;
		phase_st[5]   = occ_ff == '0;
		phase_st[4]   = cnt_ff == 16'h0000;
		phase_st[3]   = st_ff == ST_XFER;
		phase_st[2:0] = i_bus_phase;                           // RL12
	end

	logic [DATA_W-1:0] nxt_rdata;
	always_comb begin
		nxt_rdata = '0;
		case (i_addr)
			OFS_COUNT_LOW:  nxt_rdata[7:0] = cnt_ff[7:0];      // RL17
			OFS_COUNT_HIGH: nxt_rdata[7:0] = cnt_ff[15:8];     // RL17
			OFS_DATA_PORT:  nxt_rdata[7:0] = occ_ff != '0 ? bot_byte : 8'h00;
			OFS_OP_QUEUE:   nxt_rdata[7:0] = head;
			OFS_PHASE_ID:   nxt_rdata[7:0] = phase_st;         // RL17
			OFS_CAUSE_TMO:  nxt_rdata[7:0] = cause_ff;         // RL17
			OFS_SEQ_STEP:   nxt_rdata[7:0] = seq_ff;
			OFS_CONFIG3:    nxt_rdata[7:0] = cfg3_ff;
			OFS_IRQ_STAT:   nxt_rdata[IRQ_W-1:0] = ist_ff;
			OFS_IRQ_MASK:   nxt_rdata[IRQ_W-1:0] = imask_ff;
			default:        nxt_rdata = '0;
		endcase
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			o_rdata <= '0;
		else
			o_rdata <= i_rd ? nxt_rdata : '0;
	end
endmodule : scr_core_regs

// ===== scr_pkg.sv
/*
 * scr_pkg: constants and types for the scsi core register interface.
 * assumes a byte-addressed register port with 32-bit data and one
 * register per aligned word.
 */
package scr_pkg;
	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 28;
	localparam int          DATA_W         = 32;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [27:0] OFS_COUNT_LOW  = 28'h8810000;
	localparam logic [27:0] OFS_COUNT_HIGH = 28'h8810004;
	localparam logic [27:0] OFS_DATA_PORT  = 28'h8810008;
	localparam logic [27:0] OFS_OP_QUEUE   = 28'h881000c;
	localparam logic [27:0] OFS_PHASE_ID   = 28'h8810010;
	localparam logic [27:0] OFS_CAUSE_TMO  = 28'h8810014;
	localparam logic [27:0] OFS_SEQ_STEP   = 28'h8810018;
	localparam logic [27:0] OFS_CONFIG3    = 28'h8810030;
	localparam logic [27:0] OFS_IRQ_STAT   = 28'h8810040;
	localparam logic [27:0] OFS_IRQ_MASK   = 28'h8810044;
	// ----------------------------------------------------------------
	// field positions and values
	// ----------------------------------------------------------------
	localparam int          CFG3_PAD_BIT   = 7;
	localparam logic [7:0]  CFG3_RESET     = 8'h00;
	localparam logic [3:0]  OP_NOP         = 4'h0;
	localparam logic [3:0]  OP_FLUSH       = 4'h1;
	localparam logic [3:0]  OP_XFER        = 4'h2;
	localparam int          CAUSE_DONE_BIT = 3;
	localparam logic [7:0]  SEQ_DONE       = 8'h04;
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_ODD_HELD   = 1;
	localparam int          IRQ_REFUSED    = 2;
	localparam int          IRQ_W          = 3;
	localparam logic [7:0]  PAD_BYTE       = 8'h00;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       dma;
		logic [2:0] mode;
		logic [3:0] op;
	} scr_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        padded;
		logic [15:0] data;
	} scr_dma_word_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XFER,
		ST_DONE
	} scr_state_t;
endpackage : scr_pkg

// ===== scr_core_regs_asserts.sv
/*
 * scr_core_regs_asserts: port-level checker for the scsi core register bank.
 * assumes the register map and timing that scr_pkg declares.
 */
`timescale 1ns/1ps
module scr_core_regs_asserts
	import scr_pkg::*;
(
	// clock and reset
	input wire logic                i_ref_clk,
	input wire logic                i_reset_n,
	// watched ports
	input wire logic [ADDR_W-1:0]   i_addr,
	input wire logic [DATA_W-1:0]   i_wdata,
	input wire logic                i_wr,
	input wire logic                i_rd,
	input wire logic [DATA_W-1:0]   o_rdata,
	input wire logic [2:0]          i_bus_phase,
	input wire logic                i_dma_rd,
	input wire scr_dma_word_t       o_dma_word,
	input wire logic                o_dma_avail,
	input wire logic [7:0]          o_bus_id,
	input wire logic [7:0]          o_sel_timeout,
	input wire logic                o_irq
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not idle");
	AST_ID_WRITE: assert property (
		i_wr && i_addr == OFS_PHASE_ID |=> o_bus_id == $past(i_wdata[7:0]))
		else $error("bus id not stored");
	AST_TMO_WRITE: assert property (
		i_wr && i_addr == OFS_CAUSE_TMO |=> o_sel_timeout == $past(i_wdata[7:0]))
		else $error("time-out not stored");
	AST_PHASE_READ: assert property (
		i_rd && i_addr == OFS_PHASE_ID |=> o_rdata[2:0] == $past(i_bus_phase))
		else $error("bus phase not reported");
	AST_CAUSE_CLEAR: assert property (
		i_rd && i_addr == OFS_CAUSE_TMO ##2 i_rd && i_addr == OFS_CAUSE_TMO
		|=> o_rdata == 32'h0)
		else $error("cause not cleared by read");
	AST_SEQ_CLEAR: assert property (
		i_rd && i_addr == OFS_CAUSE_TMO ##2 i_rd && i_addr == OFS_SEQ_STEP
		|=> o_rdata == 32'h0)
		else $error("sequence step not cleared");
	AST_DMA_CAUSE: assert property (o_dma_word.valid |-> $past(i_dma_rd))
		else $error("dma word without request");
	AST_DMA_REFUSE: assert property (i_dma_rd && !o_dma_avail |=> !o_dma_word.valid)
		else $error("dma word from empty queue");
	AST_MASK_ZERO: assert property (
		i_wr && i_addr == OFS_IRQ_MASK && i_wdata[2:0] == 3'h0 |=> ##1 !o_irq)
		else $error("irq high with mask clear");
	AST_CFG3_RW: assert property (
		i_wr && i_addr == OFS_CONFIG3 ##2 i_rd && i_addr == OFS_CONFIG3
		|=> o_rdata[7] == $past(i_wdata[7], 3))
		else $error("pad option bit not kept");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	CV_PADDED: cover property (o_dma_word.valid && o_dma_word.padded);
	CV_IRQ: cover property ($rose(o_irq));
	CV_CAUSE: cover property (i_rd && i_addr == OFS_CAUSE_TMO ##1 o_rdata != 32'h0);
endmodule : scr_core_regs_asserts

bind scr_core_regs scr_core_regs_asserts u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_bus_phase(i_bus_phase), .i_dma_rd(i_dma_rd), .o_dma_word(o_dma_word),
	.o_dma_avail(o_dma_avail), .o_bus_id(o_bus_id), .o_sel_timeout(o_sel_timeout), .o_irq(o_irq));

// ===== scr_far_model.sv
/*
 * scr_far_model: scsi byte source and dma channel engine behind the bank.
 * assumes bytes are only offered while a transfer runs.
 */
`timescale 1ns/1ps
module scr_far_model
	import scr_pkg::*;
(
	// clock and reset
	input wire logic          i_ref_clk,
	input wire logic          i_reset_n,
	// control from the bench
	input wire logic          i_start,
	input wire logic [15:0]   i_count,
	input wire logic          i_en,
	input wire logic          i_slow,
	// scsi side
	input wire logic          i_ready,
	output logic              o_valid,
	output logic [7:0]        o_byte,
	// engine side
	input wire scr_dma_word_t i_word,
	input wire logic          i_avail,
	output logic              o_dma_rd,
	output logic [15:0]       o_got,
	output scr_dma_word_t     o_last
);
	logic [15:0] left;
	logic [7:0]  k;
	logic [2:0]  tick;

	// byte source: level valid, lines inverted while idle
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			left <= 16'h0;
			k <= 8'h0;
		end else if (i_start) begin
			left <= i_count;
		end else if (o_valid && i_ready) begin
			left <= left - 16'h1;
			k <= k + 8'h1;
		end
	end
	assign o_valid = (left != 16'h0);
	assign o_byte = o_valid ? 8'h30 + k : ~(8'h2f + k);

	// engine drains words from the bottom, promptly or every eighth cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_dma_rd <= 1'b0;
			tick <= 3'h0;
			o_got <= 16'h0;
			o_last <= '0;
		end else begin
			tick <= tick + 3'h1;
			o_dma_rd <= i_en && i_avail && !o_dma_rd && (!i_slow || tick == 3'h0);
			if (i_word.valid) begin
				o_got <= o_got + 16'h1;
				o_last <= i_word;
			end
		end
	end
endmodule : scr_far_model

// ===== scr_core_regs_tb_top.sv
/*
 * scr_core_regs_tb_top: self-checking bench for the scsi core register bank.
 * assumes scr_far_model stands at the scsi and engine side.
 */
`timescale 1ns/1ps
module scr_core_regs_tb_top;
	import scr_pkg::*;
	logic              i_ref_clk, i_reset_n, i_wr, i_rd, o_scsi_ready;
	logic              i_scsi_valid, i_dma_rd, o_dma_avail, o_irq;
	logic              m_start, m_en, m_slow;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	logic [7:0]        i_scsi_byte, o_bus_id, o_sel_timeout;
	logic [2:0]        i_bus_phase;
	logic [15:0]       m_count, m_got;
	scr_dma_word_t     o_dma_word, m_last;
	int                failures, check_count;

	scr_core_regs DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_scsi_valid(i_scsi_valid), .i_scsi_byte(i_scsi_byte), .o_scsi_ready(o_scsi_ready),
		.i_bus_phase(i_bus_phase), .i_dma_rd(i_dma_rd), .o_dma_word(o_dma_word),
		.o_dma_avail(o_dma_avail), .o_bus_id(o_bus_id), .o_sel_timeout(o_sel_timeout),
		.o_irq(o_irq));
	scr_far_model u_far (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_start(m_start),
		.i_count(m_count), .i_en(m_en), .i_slow(m_slow), .i_ready(o_scsi_ready),
		.o_valid(i_scsi_valid), .o_byte(i_scsi_byte), .i_word(o_dma_word),
		.i_avail(o_dma_avail), .o_dma_rd(i_dma_rd), .o_got(m_got), .o_last(m_last));

	// 250 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [27:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= {24'h0, d};
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [27:0] a, input logic [7:0] exp, input string what);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		cmp(o_rdata, {24'h0, exp}, what);
	endtask : rd

	task automatic send(input logic [15:0] n);
		@(posedge i_ref_clk);
		m_start <= 1'b1;
		m_count <= n;
		@(posedge i_ref_clk);
		m_start <= 1'b0;
		for (int i = 0; i < 4000 && (i < 2 || i_scsi_valid); i++) @(negedge i_ref_clk);
		if (i_scsi_valid !== 1'b0) begin
			failures++;
			report_and_stop();
		end
	endtask : send

	task automatic wait_irq;
		for (int i = 0; i < 4000 && o_irq !== 1'b1; i++) @(negedge i_ref_clk);
		if (o_irq !== 1'b1) begin
			failures++;
			report_and_stop();
		end
	endtask : wait_irq

	task automatic do_reset;
		i_reset_n <= 1'b0;
		repeat (16) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
	endtask : do_reset

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_idle;
		rd(OFS_CONFIG3, 8'h00, "pad bit at reset");
		rd(OFS_CAUSE_TMO, 8'h00, "cause at reset");
		rd(OFS_PHASE_ID, 8'h31, "idle phase status");
		// a second bus phase so the phase field is really followed
		@(posedge i_ref_clk);
		i_bus_phase <= 3'h6;
		rd(OFS_PHASE_ID, 8'h36, "other bus phase");
		@(posedge i_ref_clk);
		i_bus_phase <= 3'h1;
		rd(28'h881001c, 8'h00, "unmapped read");
		wr(OFS_PHASE_ID, 8'ha5);
		wr(OFS_CAUSE_TMO, 8'h5a);
		rd(OFS_PHASE_ID, 8'h31, "status behind id");
		rd(OFS_CAUSE_TMO, 8'h00, "cause behind time-out");
		cmp({24'h0, o_bus_id}, 32'ha5, "bus id");
		cmp({24'h0, o_sel_timeout}, 32'h5a, "time-out");
		$display("test idle done");
	endtask : t_idle

	task automatic t_odd_hold;
		wr(OFS_IRQ_MASK, 8'h07);
		wr(OFS_COUNT_LOW, 8'h03);
		wr(OFS_COUNT_HIGH, 8'h01);
		wr(OFS_OP_QUEUE, 8'h82);
		repeat (4) @(posedge i_ref_clk);
		send(16'd2);
		repeat (4) @(posedge i_ref_clk);
		rd(OFS_COUNT_LOW, 8'h01, "counter low mid");
		rd(OFS_COUNT_HIGH, 8'h01, "counter high mid");
		rd(OFS_PHASE_ID, 8'h29, "running status");
		m_slow <= 1'b1;
		send(16'd257);
		wait_irq();
		rd(OFS_IRQ_STAT, 8'h03, "done with byte held");
		rd(OFS_PHASE_ID, 8'h91, "one byte left");
		cmp({16'h0, m_got}, 32'd129, "words drained");
		rd(OFS_SEQ_STEP, SEQ_DONE, "step latched");
		rd(OFS_CAUSE_TMO, 8'h08, "cause");
		rd(OFS_CAUSE_TMO, 8'h00, "cause cleared");
		rd(OFS_SEQ_STEP, 8'h00, "step cleared");
		m_en <= 1'b0;
		wr(OFS_DATA_PORT, PAD_BYTE);
		rd(OFS_DATA_PORT, 8'h32, "held byte");
		rd(OFS_DATA_PORT, PAD_BYTE, "pad byte");
		wr(OFS_IRQ_STAT, 8'h07);
		repeat (3) @(negedge i_ref_clk);
		cmp({31'h0, o_irq}, 32'h0, "irq cleared");
		$display("test odd hold done");
	endtask : t_odd_hold

	task automatic t_pad;
		m_en <= 1'b1;
		m_slow <= 1'b0;
		wr(OFS_CONFIG3, 8'h80);
		rd(OFS_CONFIG3, 8'h80, "pad bit set");
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_COUNT_LOW, 8'h03);
		wr(OFS_COUNT_HIGH, 8'h00);
		wr(OFS_OP_QUEUE, 8'h82);
		wr(OFS_OP_QUEUE, 8'h00);
		wr(OFS_OP_QUEUE, 8'h00);
		rd(OFS_PHASE_ID, 8'h69, "op queue full");
		rd(OFS_OP_QUEUE, 8'h82, "head op");
		send(16'd3);
		wait_irq();
		repeat (8) @(posedge i_ref_clk);
		rd(OFS_IRQ_STAT, 8'h05, "padded done");
		cmp({16'h0, m_got}, 32'd131, "words drained");
		cmp({14'h0, m_last}, 32'h30035, "padded word");
		rd(OFS_CAUSE_TMO, 8'h08, "cause");
		rd(OFS_PHASE_ID, 8'h31, "queue empty");
		// flush operation empties a queue holding one host byte
		wr(OFS_DATA_PORT, 8'h5c);
		wr(OFS_OP_QUEUE, {4'h0, OP_FLUSH});
		rd(OFS_DATA_PORT, 8'h00, "flushed queue");
		@(posedge i_ref_clk);
		do_reset();
		rd(OFS_CONFIG3, 8'h00, "pad bit after reset");
		$display("test pad done");
	endtask : t_pad

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		failures = 0;
		check_count = 0;
		{i_wr, i_rd, m_start, m_slow} = 4'h0;
		m_en = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		m_count = 16'h0;
		i_bus_phase = 3'h1;
		do_reset();
		t_idle();
		t_odd_hold();
		t_pad();
		report_and_stop();
	end
endmodule : scr_core_regs_tb_top
